/* include/dsp_ops_regs.svh */
`ifndef DSP_OPS_REGS_SVH
`define DSP_OPS_REGS_SVH
// store opcodes (4-bit memory-operation field)
`define OP_MUL_TO_DATA      4'h1
`define OP_FIRST_TO_DATA    4'h2
`define OP_SECOND_TO_DATA   4'h3
`define OP_DELAY_TO_DATA    4'h4
`define OP_AUDIO_TO_DATA    4'h6
`define OP_SECOND_TO_COEFFICIENT_SPACE   4'h6
`define OP_SECOND_TO_COEF2  4'h7
`define OP_FIRST_TO_COEFFICIENT_SPACE    4'h8
// alu opcodes (5-bit field)
`define OP_PASS_FIRST       5'h10
`define OP_PASS_SECOND      5'h11
`define OP_HALT          5'h15
`define OP_JUMP          5'h12
// widths and timing
`define DATA_W           48
`define COEFFICIENT_SPACE_W           28
`define ADDR_W           10
`define PC_W             11
`define CHAN_SEL_W       3
`define STORE_LAT_CYC    2
`endif

/* include/dsp_ops_pkg.sv */
package dsp_ops_pkg;
  typedef logic [47:0] word_t;
  typedef logic [27:0] coefficient_space_t;
  typedef logic [9:0]  addr_t;
  typedef enum logic [1:0] {
    run_s  = 2'b00,
    halt_s = 2'b01
  } ctrl_state_t;
endpackage : dsp_ops_pkg

/* include/mem_wr_if.sv */
`timescale 1ns/1ns
`default_nettype none
// one write port towards a memory
interface mem_wr_if #(parameter int W = 48);
  logic          we;
  logic [9:0]    addr;
  logic [W-1:0]  data;
  modport src (output we, output addr, output data);
  modport dst (input we, input addr, input data);
endinterface : mem_wr_if
`default_nettype wire

/* verilog/store_pipe.sv */
`timescale 1ns/1ns
`default_nettype none
`include "dsp_ops_regs.svh"
// two-stage write delay, value lands two cycles after the store executes
module store_pipe
  import dsp_ops_pkg::*;
#(parameter int W = 48) (
  input  wire logic          mclk,
  input  wire logic          rstn,
  input  wire logic          in_we,
  input  wire logic [9:0]    in_addr,
  input  wire logic [W-1:0]  in_data,
  mem_wr_if.src              wr
);
  typedef struct packed {
    logic [1:0]         we;
    logic [1:0][9:0]    addr;
    logic [1:0][W-1:0]  data;
  } pipe_t;
  pipe_t pipe_r;
  pipe_t pipe_nxt;

  // shift one stage per cycle
  always_comb begin
    pipe_nxt      = pipe_r;
    pipe_nxt.we   = {pipe_r.we[0], in_we};
    pipe_nxt.addr = {pipe_r.addr[0], in_addr};
    pipe_nxt.data = {pipe_r.data[0], in_data};
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      pipe_r <= '0;
    end else begin
      pipe_r <= pipe_nxt;
    end
  end

  assign wr.we   = pipe_r.we[1];
  assign wr.addr = pipe_r.addr[1];
  assign wr.data = pipe_r.data[1];

  property p_lat;
    @(posedge mclk) disable iff (!rstn)
      in_we |-> ##2 (wr.we && wr.addr == $past(in_addr, 2));
  endproperty
  a_lat: assert property (p_lat) else $error("store latency wrong");
endmodule : store_pipe
`default_nettype wire

/* verilog/dsp_store_halt_passthru_ops.sv */
// How it works
// - a coefficient store writes the low 28 bits of second operand or first operand to a 10-bit coefficient address.
// - every stored value appears in memory two cycles after the store executes.
// - opcode 0110 in stage 1 copies the audio input register to the data RAM.
// - the low three address bits pick which audio input channel is copied.
// - opcode 0100 copies the delay output register to the data RAM.
// - opcodes 0011, 0001, 0010 write the full second operand, multiplier data or first operand to data RAM.
// - the halt opcode 10101 stops the program counter advancing.
// - pass-through 10000 copies first operand to first result, 10001 second operand to second result.
`timescale 1ns/1ns
`default_nettype none
`include "dsp_ops_regs.svh"
module dsp_store_halt_passthru_ops
  import dsp_ops_pkg::*;
(
  input  wire logic          mclk,
  input  wire logic          rstn,
  input  wire logic          instr_valid,
  input  wire logic [4:0]    alu_op,
  input  wire logic [3:0]    stage1_op,
  input  wire logic [9:0]    stage1_addr,
  input  wire logic [3:0]    stage2_op,
  input  wire logic [9:0]    stage2_addr,
  input  wire logic [10:0]   jump_target_marker,
  input  wire logic [47:0]   first_operand,
  input  wire logic [47:0]   second_operand,
  input  wire logic [47:0]   multiplier_data_reg,
  input  wire logic [7:0][47:0] audio_input_reg,
  input  wire logic [47:0]   delay_output_reg,
  output logic [10:0]        program_counter,
  output logic               halted,
  output logic [47:0]        first_result_reg,
  output logic [47:0]        second_result_reg,
  output logic               data_we,
  output logic [9:0]         data_addr,
  output logic [47:0]        data_wdata,
  output logic               coefficient_space_we,
  output logic [9:0]         coefficient_space_addr,
  output logic [27:0]        coefficient_space_wdata
);
  typedef struct packed {
    ctrl_state_t  run_state;
    logic [10:0]  prog_cnt;
    word_t        first_res;
    word_t        second_res;
  } state_t;
  state_t state_r;
  state_t state_nxt;

  logic        d_we;
  logic [47:0] d_data;
  logic        c_we;
  logic [27:0] c_data;

  // channel select from the low address bits
  function automatic word_t pick_chan(input logic [7:0][47:0] ch, input addr_t a);
    pick_chan = ch[a[`CHAN_SEL_W-1:0]];
  endfunction : pick_chan

  // stage 1 decode: data ram only; sources are read, never written
  always_comb begin
    d_we   = 1'b0;
    d_data = '0;
    if (instr_valid && state_r.run_state == run_s) begin
      case (stage1_op)
        `OP_SECOND_TO_DATA: begin
          d_we   = 1'b1;
          d_data = second_operand;
        end
        `OP_MUL_TO_DATA: begin
          d_we   = 1'b1;
          d_data = multiplier_data_reg;
        end
        `OP_FIRST_TO_DATA: begin
          d_we   = 1'b1;
          d_data = first_operand;
        end
        `OP_AUDIO_TO_DATA: begin
          d_we   = 1'b1;
          d_data = pick_chan(audio_input_reg, stage1_addr);
        end
        `OP_DELAY_TO_DATA: begin
          d_we   = 1'b1;
          d_data = delay_output_reg;
        end
        default: d_we = 1'b0;
      endcase
    end
  end

  // stage 2 decode: coefficient ram only, low 28 bits kept
  always_comb begin
    c_we   = 1'b0;
    c_data = '0;
    if (instr_valid && state_r.run_state == run_s) begin
      case (stage2_op)
        `OP_SECOND_TO_COEFFICIENT_SPACE,
        `OP_SECOND_TO_COEF2: begin
          c_we   = 1'b1;
          c_data = second_operand[`COEFFICIENT_SPACE_W-1:0];
        end
        `OP_FIRST_TO_COEFFICIENT_SPACE: begin
          c_we   = 1'b1;
          c_data = first_operand[`COEFFICIENT_SPACE_W-1:0];
        end
        default: c_we = 1'b0;
      endcase
    end
  end

  // program counter, halt and pass-through
  always_comb begin
    state_nxt = state_r;
    case (state_r.run_state)
      run_s: begin
        if (instr_valid) begin
          case (alu_op)
            `OP_HALT: state_nxt.run_state = halt_s;
            `OP_JUMP: state_nxt.prog_cnt = jump_target_marker;
            `OP_PASS_FIRST: state_nxt.first_res = first_operand;
            `OP_PASS_SECOND: state_nxt.second_res = second_operand;
            default: state_nxt.first_res = state_r.first_res;
          endcase
          if (alu_op != `OP_HALT && alu_op != `OP_JUMP) begin
            state_nxt.prog_cnt = state_r.prog_cnt + 11'h001;
          end
        end
      end
      halt_s: state_nxt.prog_cnt = state_r.prog_cnt; // frozen until reset
      default: state_nxt.run_state = run_s;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  mem_wr_if #(.W(48)) dwr ();
  mem_wr_if #(.W(28)) cwr ();

  // both spaces share the same two-cycle write latency
  store_pipe #(.W(48)) u_dpipe (
    .mclk    (mclk),
    .rstn    (rstn),
    .in_we   (d_we),
    .in_addr (stage1_addr),
    .in_data (d_data),
    .wr      (dwr.src)
  );
  store_pipe #(.W(28)) u_cpipe (
    .mclk    (mclk),
    .rstn    (rstn),
    .in_we   (c_we),
    .in_addr (stage2_addr),
    .in_data (c_data),
    .wr      (cwr.src)
  );

  assign data_we           = dwr.we;
  assign data_addr         = dwr.addr;
  assign data_wdata        = dwr.data;
  assign coefficient_space_we           = cwr.we;
  assign coefficient_space_addr         = cwr.addr;
  assign coefficient_space_wdata        = cwr.data;
  assign program_counter   = state_r.prog_cnt;
  assign halted            = (state_r.run_state == halt_s);
  assign first_result_reg  = state_r.first_res;
  assign second_result_reg = state_r.second_res;

  property p_halt_freeze;
    @(posedge mclk) disable iff (!rstn)
      // the reset edge itself clears the halt, so no attempt starts there
      (rstn && halted) |=> (halted && $stable(program_counter));
  endproperty
  a_halt_freeze: assert property (p_halt_freeze) else $error("pc moved while halted");

  property p_halt_enter;
    @(posedge mclk) disable iff (!rstn)
      (instr_valid && !halted && alu_op == `OP_HALT) |=> halted;
  endproperty
  a_halt_enter: assert property (p_halt_enter) else $error("halt not taken");

  property p_pass_first;
    @(posedge mclk) disable iff (!rstn)
      (instr_valid && !halted && alu_op == `OP_PASS_FIRST)
        |=> first_result_reg == $past(first_operand);
  endproperty
  a_pass_first: assert property (p_pass_first) else $error("first pass wrong");

  property p_pass_second;
    @(posedge mclk) disable iff (!rstn)
      (instr_valid && !halted && alu_op == `OP_PASS_SECOND)
        |=> second_result_reg == $past(second_operand);
  endproperty
  a_pass_second: assert property (p_pass_second) else $error("second pass wrong");

  property p_coefficient_space;
    @(posedge mclk) disable iff (!rstn)
      (instr_valid && !halted && stage2_op == `OP_FIRST_TO_COEFFICIENT_SPACE)
        |-> ##2 (coefficient_space_we && coefficient_space_wdata == $past(first_operand[27:0], 2));
  endproperty
  a_coefficient_space: assert property (p_coefficient_space) else $error("coefficient_space store wrong");

  property p_dstore;
    @(posedge mclk) disable iff (!rstn)
      (instr_valid && !halted && stage1_op == `OP_MUL_TO_DATA)
        |-> ##2 (data_we && data_wdata == $past(multiplier_data_reg, 2));
  endproperty
  a_dstore: assert property (p_dstore) else $error("data store wrong");

  property p_dly;
    @(posedge mclk) disable iff (!rstn)
      (instr_valid && !halted && stage1_op == `OP_DELAY_TO_DATA)
        |-> ##2 (data_wdata == $past(delay_output_reg, 2));
  endproperty
  a_dly: assert property (p_dly) else $error("delay store wrong");

  property p_di;
    @(posedge mclk) disable iff (!rstn)
      (instr_valid && !halted && stage1_op == `OP_AUDIO_TO_DATA && stage1_addr[2:0] == 3'h1)
        |-> ##2 (data_wdata == $past(audio_input_reg[1], 2));
  endproperty
  a_di: assert property (p_di) else $error("input channel wrong");

  property p_nowr_halt;
    @(posedge mclk) disable iff (!rstn)
      halted[*3] |-> !data_we && !coefficient_space_we;
  endproperty
  a_nowr_halt: assert property (p_nowr_halt) else $error("write while halted");

  c_halt: cover property (@(posedge mclk) disable iff (!rstn) $rose(halted));
  c_dwr: cover property (@(posedge mclk) disable iff (!rstn) data_we);
  c_cwr: cover property (@(posedge mclk) disable iff (!rstn) coefficient_space_we);
endmodule : dsp_store_halt_passthru_ops
`default_nettype wire

/* tb/ram_model.sv */
`timescale 1ns/1ns
`default_nettype none
// memory behind one store port; the bench reads its contents back
module ram_model #(parameter int W = 48) (
  input wire logic         mclk,
  input wire logic         we,
  input wire logic [9:0]   addr,
  input wire logic [W-1:0] wdata
);
  logic [W-1:0] mem [1024];
  // write lands on the edge that samples the strobe, like a plain sync ram
  always @(posedge mclk) begin
    if (we === 1'b1) mem[addr] <= wdata;
  end
endmodule : ram_model
`default_nettype wire

/* tb/tb.sv */
`timescale 1ns/1ns
`default_nettype none
`include "dsp_ops_regs.svh"
module tb;
  import dsp_ops_pkg::*;
  typedef struct {logic [3:0] s1; logic [9:0] a1; logic [3:0] s2; logic [9:0] a2;
                  logic [47:0] exp;} row_t;
  logic mclk, rstn, instr_valid, halted, data_we, coefficient_space_we;
  logic [4:0] alu_op;
  logic [3:0] stage1_op, stage2_op;
  logic [9:0] stage1_addr, stage2_addr, data_addr, coefficient_space_addr;
  logic [10:0] jump_target_marker, program_counter;
  logic [47:0] first_operand, second_operand, multiplier_data_reg, delay_output_reg;
  logic [47:0] first_result_reg, second_result_reg, data_wdata;
  logic [7:0][47:0] audio_input_reg;
  logic [27:0] coefficient_space_wdata;
  row_t rows [9];
  int n_errors, comparisons, n_instr, lat, pc_halt;
  localparam logic [47:0] FO = 48'h1234_5678_9123, SO = 48'h0000_0678_9123;
  localparam logic [47:0] MUL_VAL = 48'h0bad_cafe_0001, DL = 48'h00de_1a70_0042;

  dsp_store_halt_passthru_ops dsp_store_halt_passthru_ops_i (
    .mclk                (mclk),
    .rstn                (rstn),
    .instr_valid         (instr_valid),
    .alu_op              (alu_op),
    .stage1_op           (stage1_op),
    .stage1_addr         (stage1_addr),
    .stage2_op           (stage2_op),
    .stage2_addr         (stage2_addr),
    .jump_target_marker  (jump_target_marker),
    .first_operand       (first_operand),
    .second_operand      (second_operand),
    .multiplier_data_reg (multiplier_data_reg),
    .audio_input_reg     (audio_input_reg),
    .delay_output_reg    (delay_output_reg),
    .program_counter     (program_counter),
    .halted              (halted),
    .first_result_reg    (first_result_reg),
    .second_result_reg   (second_result_reg),
    .data_we             (data_we),
    .data_addr           (data_addr),
    .data_wdata          (data_wdata),
    .coefficient_space_we             (coefficient_space_we),
    .coefficient_space_addr           (coefficient_space_addr),
    .coefficient_space_wdata          (coefficient_space_wdata)
  );
  ram_model #(.W(48)) data_ram_i (.mclk(mclk), .we(data_we), .addr(data_addr),
                                  .wdata(data_wdata));
  ram_model #(.W(28)) coefficient_space_ram_i (.mclk(mclk), .we(coefficient_space_we), .addr(coefficient_space_addr),
                                  .wdata(coefficient_space_wdata));

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  task automatic check(input logic [47:0] seen, input logic [47:0] exp, input string msg);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask : check

  // one instruction word for one cycle, then back to idle
  task automatic issue(input logic [4:0] alu, input logic [3:0] s1, input logic [9:0] a1,
                       input logic [3:0] s2, input logic [9:0] a2);
    @(posedge mclk);
    instr_valid <= 1'b1;
    alu_op      <= alu;
    stage1_op   <= s1;
    stage1_addr <= a1;
    stage2_op   <= s2;
    stage2_addr <= a2;
    @(posedge mclk);
    instr_valid <= 1'b0;
    alu_op      <= 5'h00;
    stage1_op   <= 4'h0;
    stage2_op   <= 4'h0;
    if (alu != `OP_HALT) n_instr++;
  endtask : issue

  // count cycles from the taking edge until a write strobe shows
  task automatic wait_store;
    lat = 0;
    while (lat < 5 && data_we !== 1'b1 && coefficient_space_we !== 1'b1) begin
      @(negedge mclk);
      lat++;
    end
  endtask : wait_store

  task automatic results;
    $display("comparisons %0d, mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : results

  // whole run is well under 400 cycles
  initial begin
    repeat (2000) @(posedge mclk);
    n_errors++;
    results();
  end

  initial begin
    {rstn, instr_valid, alu_op, stage1_op, stage2_op} = '0;
    {stage1_addr, stage2_addr, jump_target_marker} = '0;
    first_operand = FO;
    second_operand = SO;
    multiplier_data_reg = MUL_VAL;
    delay_output_reg = DL;
    for (int i = 0; i < 8; i++) audio_input_reg[i] = 48'h0a0a_0000_0000 + 48'(i);
    rows = '{'{`OP_SECOND_TO_DATA, 10'h001, 4'h0, 10'h000, SO},
             '{`OP_MUL_TO_DATA, 10'h3ff, 4'h0, 10'h000, MUL_VAL},
             '{`OP_FIRST_TO_DATA, 10'h002, 4'h0, 10'h000, FO},
             '{`OP_DELAY_TO_DATA, 10'h010, 4'h0, 10'h000, DL},
             '{`OP_AUDIO_TO_DATA, 10'h005, 4'h0, 10'h000, 48'h0a0a_0000_0005},
             '{`OP_AUDIO_TO_DATA, 10'h1af, 4'h0, 10'h000, 48'h0a0a_0000_0007},
             '{4'h0, 10'h000, `OP_SECOND_TO_COEFFICIENT_SPACE, 10'h100, {20'h0, SO[27:0]}},
             '{4'h0, 10'h000, `OP_SECOND_TO_COEF2, 10'h3fe, {20'h0, SO[27:0]}},
             '{4'h0, 10'h000, `OP_FIRST_TO_COEFFICIENT_SPACE, 10'h000, {20'h0, FO[27:0]}}};
    repeat (4) @(posedge mclk);
    rstn <= 1'b1;
    @(negedge mclk);
    check({36'h0, program_counter, halted}, 48'h0, "outputs after reset");
    // stores: data ram only in stage 1, coefficient ram only in stage 2
    foreach (rows[i]) begin
      if (rows[i].s1 == `OP_DELAY_TO_DATA) begin
        repeat (13) issue(5'h00, 4'h0, 10'h0, 4'h0, 10'h0);
      end
      issue(5'h00, rows[i].s1, rows[i].a1, rows[i].s2, rows[i].a2);
      wait_store();
      check(48'(lat), 48'd2, "store latency");
      @(posedge mclk);
      @(negedge mclk);
      if (rows[i].s2 == 4'h0) check(data_ram_i.mem[rows[i].a1], rows[i].exp, "data ram");
      else check(48'(coefficient_space_ram_i.mem[rows[i].a2]), rows[i].exp, "coefficient_space ram");
    end
    check(first_result_reg, 48'h0, "results untouched by stores");
    $display("store rows done");
    // pass-through both ways, first result must stand over the second
    issue(`OP_PASS_FIRST, 4'h0, 10'h0, 4'h0, 10'h0);
    @(negedge mclk);
    check(first_result_reg, FO, "first result");
    issue(`OP_PASS_SECOND, 4'h0, 10'h0, 4'h0, 10'h0);
    @(negedge mclk);
    check(second_result_reg, SO, "second result");
    check(first_result_reg, FO, "first result held");
    check(48'(program_counter), 48'(n_instr), "pc count");
    $display("pass-through done");
    // a running jump loads its target, then three no-op instructions
    jump_target_marker <= 11'h040;
    issue(`OP_JUMP, 4'h0, 10'h0, 4'h0, 10'h0);
    @(negedge mclk);
    check(48'(program_counter), 48'h040, "jump target");
    n_instr = 32'h40;
    repeat (3) issue(5'h00, 4'h0, 10'h0, 4'h0, 10'h0);
    @(negedge mclk);
    check(48'(program_counter), 48'h043, "pc after jump");
    $display("jump done");
    // halt, then a store and the guard jump back, all ignored once halted
    pc_halt = n_instr;
    issue(`OP_HALT, 4'h0, 10'h0, 4'h0, 10'h0);
    issue(5'h00, `OP_FIRST_TO_DATA, 10'h020, 4'h0, 10'h0);
    // watch right away, a late look would miss the two-cycle strobe
    wait_store();
    check(48'(lat), 48'd5, "no store while halted");
    jump_target_marker <= 11'h000;
    issue(`OP_JUMP, 4'h0, 10'h0, 4'h0, 10'h0);
    repeat (3) issue(5'h00, 4'h0, 10'h0, 4'h0, 10'h0);
    @(negedge mclk);
    check({36'h0, program_counter, halted}, {36'h0, 11'(pc_halt), 1'b1}, "pc frozen");
    $display("halt done");
    // a second reset frees the halt
    @(posedge mclk);
    rstn <= 1'b0;
    @(posedge mclk);
    rstn <= 1'b1;
    @(negedge mclk);
    check({36'h0, program_counter, halted}, 48'h0, "outputs after second reset");
    $display("reset done");
    results();
  end
endmodule : tb
`default_nettype wire
